// ---- uic_pkg.sv ----
// Shared constants for the serial channel interrupt and FIFO control block
package uic_pkg;

    // Register byte addresses on the APB side
    localparam logic [7:0] ADDR_MASK   = 8'h00;
    localparam logic [7:0] ADDR_SOURCE = 8'h04;
    localparam logic [7:0] ADDR_LINE   = 8'h08;
    localparam logic [7:0] ADDR_MODEM  = 8'h0C;

    // Reset values
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [1:0] TRIG_RESET   = 2'h0;

    // Interrupt mask bit positions
    localparam int MASK_RX_DATA   = 0;
    localparam int MASK_TX_READY  = 1;
    localparam int MASK_LINE      = 2;
    localparam int MASK_MODEM     = 3;
    localparam int MASK_SLEEP     = 4;
    localparam int MASK_XOFF      = 5;
    localparam int MASK_RTS       = 6;
    localparam int MASK_CTS       = 7;

    // FIFO setup field positions
    localparam int FS_ENABLE      = 0;
    localparam int FS_RX_RESET    = 1;
    localparam int FS_TX_RESET    = 2;
    localparam int FS_DMA         = 3;
    localparam int FS_TX_TRIG_LO  = 4;
    localparam int FS_RX_TRIG_LO  = 6;

    // Interrupt source codes, bits 5:0
    localparam logic [5:0] CODE_LINE    = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_RX      = 6'h04;
    localparam logic [5:0] CODE_TX      = 6'h02;
    localparam logic [5:0] CODE_MODEM   = 6'h00;
    localparam logic [5:0] CODE_XOFF    = 6'h10;
    localparam logic [5:0] CODE_FLOW    = 6'h20;
    localparam logic [5:0] CODE_NONE    = 6'h01;

    // Trigger levels in characters
    localparam logic [4:0] TRIG_LVL_0 = 5'h01;
    localparam logic [4:0] TRIG_LVL_1 = 5'h04;
    localparam logic [4:0] TRIG_LVL_2 = 5'h08;
    localparam logic [4:0] TRIG_LVL_3 = 5'h0E;

    // Receive time-out: character times plus extra bit times
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_BITS  = 12;

endpackage

// ---- uic_timeout.sv ----
// Receive time-out timer counted in bit times
`timescale 1ns/1ns
module uic_timeout
    import uic_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic             bit_tick,
    input  wire logic [3:0]       char_bits,
    // Result
    output logic                  expire
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;
    logic             done;

    // Four character times plus twelve bit times
    assign limit = CNT_W'(TIMEOUT_CHARS) * CNT_W'(char_bits) + CNT_W'(TIMEOUT_BITS);

    // Counter stops at the limit: one expiry pulse per idle gap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            done  <= 1'b0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (!run || restart) begin
                count <= '0;
                done  <= 1'b0;
            end else if (bit_tick && !done) begin
                if (count + CNT_W'(1) >= limit) begin
                    done   <= 1'b1;
                    expire <= 1'b1;
                end
                count <= count + CNT_W'(1);
            end
        end
    end

endmodule

// ---- uic_top.sv ----
// Interrupt enable, priority, status, clearing and FIFO setup for one serial channel
//
// Overview of operation
// - FIFOs on with mask bits 0-3 clear gives polled mode via line status.
// - Line status: data, overrun, head errors, holding empty, all empty, any FIFO error.
// - Receive interrupt: holding full without FIFO, trigger reached with FIFO.
// - Transmit interrupt on empty or below trigger; enabling while empty raises it.
// - Line interrupt: overrun at once, head errors when faulty character read.
// - Modem interrupt whenever any modem input change flag is set.
// - Mask bits 4-7 act only with enhanced enable; all reset to zero.
// - Interrupt on RTS low-to-high under automatic RTS flow control.
// - Interrupt on CTS low-to-high under automatic CTS flow control.
// - Receive time-out after four character times plus twelve bit times.
// - Source code bits 5:0 encode sources by priority, none reads 000001.
// - Source read returns only the highest pending source; others stay queued.
// - Each source clears by its own read or write side effect.
// - Xoff, special, flow and wake indications clear as defined.
// - Leaving sleep posts a wake indication coded like no interrupt.
// - Source bit 0 is low while an interrupt other than wake is pending, high at reset.
// - Source bits 4 and 5 active only with enhanced enable.
// - Source bits 7:6 both high with FIFOs on, low with FIFOs off.
// - FIFO setup bit 0 enables FIFOs; other bits ignored unless it is one.
// - Setup bit 1 resets receive FIFO pointers, then self-clears.
// - Setup bit 2 resets transmit FIFO pointers, then self-clears.
// - Setup bit 3 selects normal or DMA signalling.
// - Receive and transmit trigger of 1, 4, 8 or 14; transmit needs enhanced.
`timescale 1ns/1ns
module uic_top
    import uic_pkg::*;
#(
    parameter int LVL_W = 5
) (
    // APB slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Receive path status and events
    input  wire logic [LVL_W-1:0] rx_level,
    input  wire logic             rx_store_event,
    input  wire logic             rx_pop_event,
    input  wire logic             rx_overrun_event,
    input  wire logic [2:0]       rx_head_error,
    input  wire logic             rx_fifo_error_any,
    // Transmit path status and events
    input  wire logic [LVL_W-1:0] tx_level,
    input  wire logic             tx_push_event,
    input  wire logic             tx_shifter_empty,
    // Timing from the baud generator
    input  wire logic             bit_tick,
    input  wire logic [3:0]       char_bits,
    // Modem inputs and flow control
    input  wire logic [3:0]       modem_state,
    input  wire logic [3:0]       modem_delta,
    input  wire logic             cts_n_pin,
    input  wire logic             rts_n,
    input  wire logic             auto_cts_en,
    input  wire logic             auto_rts_en,
    // Enhanced features and flow characters
    input  wire logic             enhanced_en,
    input  wire logic             xoff_detect,
    input  wire logic             xon_detect,
    input  wire logic             special_detect,
    input  wire logic             wake_event,
    // Outputs to the channel
    output logic                  irq,
    output logic                  rx_fifo_reset,
    output logic                  tx_fifo_reset,
    output logic                  modem_delta_clear,
    output logic                  fifo_enable,
    output logic                  dma_mode,
    output logic [1:0]            rx_trigger_sel,
    output logic [1:0]            tx_trigger_sel,
    output logic                  sleep_enable,
    output logic                  polled_mode
);

    // Map a two-bit selection to its trigger level
    function automatic logic [LVL_W-1:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'h0:    trig_level = LVL_W'(TRIG_LVL_0);
            2'h1:    trig_level = LVL_W'(TRIG_LVL_1);
            2'h2:    trig_level = LVL_W'(TRIG_LVL_2);
            default: trig_level = LVL_W'(TRIG_LVL_3);
        endcase
    endfunction

    logic [7:0] mask, mask_eff, source_val, line_val;
    logic [5:0] code;
    logic [2:0] error_flags;
    logic       setup_phase, access_done, wr_done, rd_done, rd_source, rd_line, rd_modem;
    logic       cts_meta, cts_sync, cts_prev, rts_prev;
    logic       overrun_flag, timeout_flag, timeout_expire, tx_flag, tx_cond, tx_cond_prev;
    logic       char_flag, char_is_special, flow_flag, wake_flag;
    logic       rx_ready, line_pend, modem_pend, any_pend;
    logic       shown_tx, shown_char, shown_wake;

    // APB phases; the slave never stretches a transfer
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite;
    assign rd_done     = access_done && !pwrite;
    assign rd_source   = rd_done && paddr == ADDR_SOURCE;
    assign rd_line     = rd_done && paddr == ADDR_LINE;
    assign rd_modem    = rd_done && paddr == ADDR_MODEM;

    // Upper mask bits only count with the enhanced enable set
    assign mask_eff = enhanced_en ? mask : {4'h0, mask[3:0]};

    // CTS arrives from a pin, so two flops come before any edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
            cts_prev <= 1'b1;
            rts_prev <= 1'b1;
        end else begin
            cts_meta <= cts_n_pin;
            cts_sync <= cts_meta;
            cts_prev <= cts_sync;
            rts_prev <= rts_n;
        end
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= MASK_RESET;
        end else if (wr_done && paddr == ADDR_MASK) begin
            mask <= pwdata[7:0];
        end
    end

    // FIFO setup writes; nothing but the enable bit is taken unless it is one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_enable    <= 1'b0;
            dma_mode       <= 1'b0;
            rx_trigger_sel <= TRIG_RESET;
            tx_trigger_sel <= TRIG_RESET;
            rx_fifo_reset  <= 1'b0;
            tx_fifo_reset  <= 1'b0;
        end else begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            if (wr_done && paddr == ADDR_SOURCE) begin
                fifo_enable <= pwdata[FS_ENABLE];
                if (pwdata[FS_ENABLE]) begin
                    rx_fifo_reset  <= pwdata[FS_RX_RESET];
                    tx_fifo_reset  <= pwdata[FS_TX_RESET];
                    dma_mode       <= pwdata[FS_DMA];
                    rx_trigger_sel <= pwdata[FS_RX_TRIG_LO +: 2];
                    if (enhanced_en) begin
                        tx_trigger_sel <= pwdata[FS_TX_TRIG_LO +: 2];
                    end
                end
            end
        end
    end

    // Line status error latches; a new error in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_flag <= 1'b0;
            error_flags  <= 3'h0;
        end else begin
            if (rx_overrun_event) begin
                overrun_flag <= 1'b1;
            end else if (rd_line) begin
                overrun_flag <= 1'b0;
            end
            if (rx_pop_event && rx_head_error != 3'h0) begin
                error_flags <= error_flags | rx_head_error;
            end else if (rd_line) begin
                error_flags <= 3'h0;
            end
        end
    end

    // Receive time-out timer restarts on every character in or out
    uic_timeout #(
        .CNT_W (8)
    ) u_timeout (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (fifo_enable && rx_level != '0),
        .restart   (rx_store_event || rx_pop_event),
        .bit_tick  (bit_tick),
        .char_bits (char_bits),
        .expire    (timeout_expire)
    );

    // Time-out indication; reading receive data clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b0;
        end else if (timeout_expire && mask_eff[MASK_RX_DATA]) begin
            timeout_flag <= 1'b1;
        end else if (rx_pop_event || !mask_eff[MASK_RX_DATA]) begin
            timeout_flag <= 1'b0;
        end
    end

    // Receive ready is a level, so it falls once reads drop below trigger
    assign rx_ready = mask_eff[MASK_RX_DATA] &&
                      (fifo_enable ? rx_level >= trig_level(rx_trigger_sel)
                                   : rx_level != '0);

    // Transmit condition: holding empty, or FIFO below its trigger
    assign tx_cond = fifo_enable ? tx_level < trig_level(tx_trigger_sel)
                                 : tx_level == '0;

    // Transmit ready is edge-raised and sticky, so a source read can clear it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cond_prev <= 1'b0;
            tx_flag      <= 1'b0;
        end else begin
            tx_cond_prev <= tx_cond;
            if (!mask_eff[MASK_TX_READY]) begin
                tx_flag <= 1'b0;
            end else if (tx_cond && !tx_cond_prev) begin
                tx_flag <= 1'b1;
            end else if (tx_push_event || (rd_source && shown_tx)) begin
                tx_flag <= 1'b0;
            end
            // Enabling while already empty raises it at once
            if (wr_done && paddr == ADDR_MASK && pwdata[MASK_TX_READY]
                    && !mask[MASK_TX_READY] && tx_cond) begin
                tx_flag <= 1'b1;
            end
        end
    end

    // Xoff or special character match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            char_flag       <= 1'b0;
            char_is_special <= 1'b0;
        end else if ((xoff_detect || special_detect) && mask_eff[MASK_XOFF]) begin
            char_flag       <= 1'b1;
            char_is_special <= special_detect && !xoff_detect;
        end else if (rd_source && shown_char) begin
            char_flag <= 1'b0;
        end else if (!char_is_special && xon_detect) begin
            char_flag <= 1'b0;
        end else if (char_is_special && rx_store_event) begin
            char_flag <= 1'b0;
        end
    end

    // RTS and CTS rising edges under automatic flow control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_flag <= 1'b0;
        end else if (mask_eff[MASK_CTS] && auto_cts_en && cts_sync && !cts_prev) begin
            flow_flag <= 1'b1;
        end else if (mask_eff[MASK_RTS] && auto_rts_en && rts_n && !rts_prev) begin
            flow_flag <= 1'b1;
        end else if (rd_modem) begin
            flow_flag <= 1'b0;
        end
    end

    // Wake-up indication posted on leaving sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_flag <= 1'b0;
        end else if (wake_event) begin
            wake_flag <= 1'b1;
        end else if (rd_source && shown_wake) begin
            wake_flag <= 1'b0;
        end
    end

    // Level-style pending sources
    assign line_pend  = mask_eff[MASK_LINE] && (overrun_flag || error_flags != 3'h0);
    assign modem_pend = mask_eff[MASK_MODEM] && modem_delta != 4'h0;

    // Priority encoder: only the highest pending source is shown
    always_comb begin
        if (line_pend) begin
            code = CODE_LINE;
        end else if (timeout_flag) begin
            code = CODE_TIMEOUT;
        end else if (rx_ready) begin
            code = CODE_RX;
        end else if (tx_flag) begin
            code = CODE_TX;
        end else if (modem_pend) begin
            code = CODE_MODEM;
        end else if (char_flag && enhanced_en) begin
            code = CODE_XOFF;
        end else if (flow_flag && enhanced_en) begin
            code = CODE_FLOW;
        end else begin
            code = CODE_NONE;
        end
    end

    assign any_pend   = code != CODE_NONE || wake_flag;
    assign source_val = {fifo_enable, fifo_enable, code};
    assign line_val   = {rx_fifo_error_any, tx_level == '0 && tx_shifter_empty,
                         tx_level == '0, error_flags, overrun_flag,
                         rx_level != '0};

    // Read data and what was shown are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
            shown_tx   <= 1'b0;
            shown_char <= 1'b0;
            shown_wake <= 1'b0;
        end else if (setup_phase) begin
            shown_tx   <= code == CODE_TX;
            shown_char <= code == CODE_XOFF;
            shown_wake <= code == CODE_NONE && wake_flag;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            case (paddr)
                ADDR_MASK:   prdata <= {24'h0, mask};
                ADDR_SOURCE: prdata <= {24'h0, source_val};
                ADDR_LINE: begin
                    prdata  <= {24'h0, line_val};
                    pslverr <= pwrite;
                end
                ADDR_MODEM: begin
                    prdata  <= {24'h0, modem_state, modem_delta};
                    pslverr <= pwrite;
                end
                default:     pslverr <= 1'b1;
            endcase
        end
    end

    // Ready and the interrupt line come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready            <= 1'b0;
            irq               <= 1'b0;
            modem_delta_clear <= 1'b0;
            sleep_enable      <= 1'b0;
            polled_mode       <= 1'b0;
        end else begin
            pready            <= 1'b1;
            irq               <= any_pend;
            modem_delta_clear <= rd_modem;
            sleep_enable      <= mask_eff[MASK_SLEEP];
            polled_mode       <= fifo_enable && mask[3:0] == 4'h0;
        end
    end

endmodule

// ---- uic_chk.sv ----
// Assertion checker for the interrupt and FIFO setup block
`timescale 1ns/1ns
module uic_chk
    import uic_pkg::*;
(
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Channel side
    input wire logic        rx_fifo_reset,
    input wire logic        tx_fifo_reset,
    input wire logic        modem_delta_clear,
    input wire logic        fifo_enable,
    input wire logic        dma_mode,
    input wire logic [1:0]  rx_trigger_sel
);
    logic       fw;
    logic       rd0;

    // Completed setup write; read started at that address
    assign fw  = psel && penable && pready && pwrite && paddr == ADDR_SOURCE;
    assign rd0 = psel && !penable && !pwrite && paddr == ADDR_SOURCE;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FS_OFF: assert property (
        fw && !pwdata[0] |=> !fifo_enable && !rx_fifo_reset && !tx_fifo_reset
            && $stable(dma_mode) && $stable(rx_trigger_sel))
        else $error("disabling write changed other fields");
    AST_FS_ON: assert property (
        fw && pwdata[0] |=> fifo_enable && dma_mode == $past(pwdata[3])
            && rx_trigger_sel == $past(pwdata[7:6]))
        else $error("setup fields not taken");
    AST_RX_RST: assert property (
        fw && pwdata[1] && pwdata[0] |-> ##[1:2] rx_fifo_reset)
        else $error("no receive reset");
    AST_TX_RST: assert property (
        fw && pwdata[2] && pwdata[0] |-> ##[1:2] tx_fifo_reset)
        else $error("no transmit reset");
    AST_RST_PULSE: assert property (
        rx_fifo_reset || tx_fifo_reset |-> fifo_enable ##1 !(rx_fifo_reset || tx_fifo_reset))
        else $error("bad pointer reset pulse");
    AST_NO_SIDE: assert property (
        rd0 |=> (!rx_fifo_reset && !tx_fifo_reset) [*3])
        else $error("source read caused a reset");
    AST_MDC: assert property (
        psel && penable && pready && !pwrite && paddr == ADDR_MODEM |-> ##[1:2] modem_delta_clear)
        else $error("no change flag clear");
    AST_RO_ERR: assert property (
        psel && !penable && pwrite && paddr == ADDR_LINE |=> pslverr)
        else $error("line status write accepted");
endmodule

bind uic_top uic_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .rx_fifo_reset, .tx_fifo_reset, .modem_delta_clear, .fifo_enable,
    .dma_mode, .rx_trigger_sel);

// ---- uic_host.sv ----
// Host model: APB master with one transfer task
`timescale 1ns/1ns
module uic_host (
    // APB master
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // Bus idle until the first transfer
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // Request held until pready is seen at an edge, for up to 16 edges; answer taken there
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic ok);
        ok = 1'b0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            ok = pready === 1'b1;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- uic_tb_top.sv ----
// Self-checking bench for the interrupt and FIFO setup block
`timescale 1ns/1ns
module uic_tb_top
    import uic_pkg::*;
;
    logic        pclk, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, v, evp = 8'h00;
    logic [31:0] pwdata, prdata, rd_v;
    logic        er_v, ok_v, modem_delta_clear, fifo_enable, dma_mode, sleep_enable, polled_mode;
    logic [4:0]  rx_level = 5'h00, tx_level = 5'h00;
    logic [3:0]  char_bits = 4'hA, modem_state = 4'h5, modem_delta = 4'h0;
    logic [2:0]  rx_head_error = 3'h0;
    logic [1:0]  rx_trigger_sel, tx_trigger_sel;
    logic        rx_fifo_error_any = 1'b0, tx_shifter_empty = 1'b1, bit_tick = 1'b0;
    logic        cts_n_pin = 1'b0, rts_n = 1'b0, auto_cts_en = 1'b1, auto_rts_en = 1'b1;
    logic        enhanced_en = 1'b1;
    int          num_errors = 0, tests_run = 0, i;
    integer      seed = 32'hd5e4;

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    uic_host h (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    uic_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .rx_level, .rx_store_event(evp[6]), .rx_pop_event(evp[4]),
        .rx_overrun_event(evp[3]), .rx_head_error, .rx_fifo_error_any, .tx_level,
        .tx_push_event(evp[5]), .tx_shifter_empty, .bit_tick, .char_bits, .modem_state,
        .modem_delta, .cts_n_pin, .rts_n, .auto_cts_en, .auto_rts_en, .enhanced_en,
        .xoff_detect(evp[0]), .xon_detect(evp[1]), .special_detect(evp[7]),
        .wake_event(evp[2]), .irq, .rx_fifo_reset(), .tx_fifo_reset(), .modem_delta_clear,
        .fifo_enable, .dma_mode, .rx_trigger_sel, .tx_trigger_sel, .sleep_enable, .polled_mode);

    // Expected source register with FIFOs on
    function automatic logic [7:0] src(input logic [5:0] c);
        return {2'b11, c};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One channel event pulse, one cycle wide
    task automatic pulse(input int k);
        @(posedge pclk);
        evp[k] <= 1'b1;
        @(posedge pclk);
        evp[k] <= 1'b0;
    endtask

    // Bus access; a missing pready ends the run
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        h.xfer(w, a, {24'h0, d}, rd_v, er_v, ok_v);
        if (ok_v !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: no pready", $time);
            complete_run();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rd_v, {24'h0, e});
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_SOURCE, 8'h01);
        rd(ADDR_MASK, MASK_RESET);
        chk(irq, 1'b0);
        acc(1'b1, ADDR_SOURCE, 8'hCE);
        tick(2);
        chk({fifo_enable, rx_trigger_sel}, 3'h0);
        // Every trigger code on both sides, DMA select toggled
        for (i = 0; i < 4; i++) begin
            v = {i[1:0], i[1:0], i[0], 3'h1};
            acc(1'b1, ADDR_SOURCE, v);
            tick(1);
            chk({dma_mode, rx_trigger_sel, tx_trigger_sel}, {v[3], v[7:4]});
        end
        rd(ADDR_SOURCE, 8'hC1);
        acc(1'b1, ADDR_SOURCE, 8'h07);
        // Four sources pending at once, served strictly by priority
        rx_level <= 5'h01;
        modem_delta <= 4'h1;
        rx_fifo_error_any <= 1'b1;
        pulse(3);
        acc(1'b1, ADDR_MASK, 8'h0F);
        tick(2);
        chk({irq, polled_mode}, 2'b10);
        rd(ADDR_SOURCE, src(CODE_LINE));
        rd(ADDR_LINE, 8'hE3);
        rd(ADDR_SOURCE, src(CODE_RX));
        rx_level <= 5'h00;
        tick(2);
        rd(ADDR_SOURCE, src(CODE_TX));
        rd(ADDR_SOURCE, src(CODE_MODEM));
        rd(ADDR_MODEM, {modem_state, 4'h1});
        tick(1);
        chk(modem_delta_clear, 1'b1);
        modem_delta <= 4'h0;
        tick(2);
        rd(ADDR_SOURCE, src(CODE_NONE));
        chk(irq, 1'b0);
        // Time-out below trigger 14; then a popped framing error
        acc(1'b1, ADDR_SOURCE, 8'hC1);
        acc(1'b1, ADDR_MASK, 8'h05);
        rx_level <= 5'h01;
        bit_tick <= 1'b1;
        tick(TIMEOUT_CHARS * 10 + TIMEOUT_BITS - 12);
        rd(ADDR_SOURCE, src(CODE_NONE));
        tick(20);
        rd(ADDR_SOURCE, src(CODE_TIMEOUT));
        rx_head_error <= 3'h2;
        pulse(4);
        rx_level <= 5'h00;
        bit_tick <= 1'b0;
        tick(2);
        rd(ADDR_SOURCE, src(CODE_LINE));
        rd(ADDR_LINE, 8'hE8);
        rd(ADDR_SOURCE, src(CODE_NONE));
        // Xoff cleared by Xon, special by next character, both by a source read
        acc(1'b1, ADDR_MASK, 8'h20);
        for (i = 0; i < 2; i++) begin
            pulse(i * 7);
            pulse(i ? 6 : 1);
            rd(ADDR_SOURCE, src(CODE_NONE));
            pulse(i * 7);
            rd(ADDR_SOURCE, src(CODE_XOFF));
            rd(ADDR_SOURCE, src(CODE_NONE));
        end
        // Flow pins rising under automatic control; a modem read clears them
        acc(1'b1, ADDR_MASK, 8'hC0);
        for (i = 0; i < 2; i++) begin
            v = 8'($random(seed));
            modem_state <= v[3:0];
            {rts_n, cts_n_pin} <= i ? 2'b11 : 2'b01;
            tick(5);
            rd(ADDR_SOURCE, src(CODE_FLOW));
            rd(ADDR_MODEM, {v[3:0], 4'h0});
            rd(ADDR_SOURCE, src(CODE_NONE));
        end
        acc(1'b1, ADDR_MASK, 8'hF0);
        pulse(2);
        tick(2);
        chk({irq, sleep_enable}, 2'b11);
        rd(ADDR_SOURCE, src(CODE_NONE));
        tick(2);
        chk(irq, 1'b0);
        // Random masks read back; all clear with FIFOs on means polled
        repeat (8) begin
            v = 8'($random(seed));
            acc(1'b1, ADDR_MASK, v);
            rd(ADDR_MASK, v);
        end
        acc(1'b1, ADDR_MASK, 8'h00);
        tick(2);
        chk(polled_mode, 1'b1);
        rd(8'h10, 8'h00);
        chk(er_v, 1'b1);
        acc(1'b1, ADDR_LINE, 8'hFF);
        chk(er_v, 1'b1);
        // Enhanced mask bits have no effect with enhanced features off
        enhanced_en <= 1'b0;
        acc(1'b1, ADDR_MASK, 8'h20);
        pulse(0);
        tick(2);
        chk(irq, 1'b0);
        complete_run();
    end
endmodule
